// file: common/output_router_pkg.sv
package output_router_pkg;

  localparam int FUNC_W = 4;
  typedef logic [FUNC_W-1:0] func_code_t;

  // Output function codes; thirteen functions occupy 0x0 to 0xC.
  localparam func_code_t FN_HEAT = 4'h0;
  localparam func_code_t FN_COOL = 4'h1;
  localparam func_code_t FN_ALARM1 = 4'h2;
  localparam func_code_t FN_ALARM2 = 4'h3;
  localparam func_code_t FN_ALARM3 = 4'h4;
  localparam func_code_t FN_HEATER_BURNOUT = 4'h5;
  localparam func_code_t FN_LOOP_BREAK = 4'h6;
  localparam func_code_t FN_TIME_SIGNAL1 = 4'h7;
  localparam func_code_t FN_TIME_SIGNAL2 = 4'h8;
  localparam func_code_t FN_PROGRAM_END = 4'h9;
  localparam func_code_t FN_STAGE = 4'hA;
  localparam func_code_t FN_INPUT_ERROR = 4'hB;
  localparam func_code_t FN_ADC_ERROR = 4'hC;
  localparam int NUM_FUNC_CODES = 16;

  // Destination indices.
  localparam int NUM_DEST = 4;
  typedef logic [1:0] dest_idx_t;
  localparam dest_idx_t DEST_CTL1 = 2'h0;
  localparam dest_idx_t DEST_CTL2 = 2'h1;
  localparam dest_idx_t DEST_AUX1 = 2'h2;
  localparam dest_idx_t DEST_AUX2 = 2'h3;
  typedef logic [NUM_DEST-1:0][FUNC_W-1:0] dest_map_t;

  // Factory assignment defaults.
  localparam func_code_t DEFAULT_CTL1 = FN_HEAT;
  localparam func_code_t DEFAULT_CTL2 = FN_ALARM1;
  localparam func_code_t DEFAULT_AUX1 = FN_ALARM2;
  localparam func_code_t DEFAULT_AUX2 = FN_ALARM3;

  localparam logic DIR_REVERSE = 1'b0;
  localparam logic DIR_DIRECT = 1'b1;
  localparam logic DEFAULT_DIRECTION = DIR_REVERSE;

  // Control periods in whole seconds.
  localparam int PERIOD_W = 7;
  typedef logic [PERIOD_W-1:0] period_t;
  localparam period_t PERIOD_HEAT_DEFAULT_S = 7'h14;
  localparam period_t PERIOD_COOL_DEFAULT_S = 7'h14;
  localparam period_t PERIOD_MIN_S = 7'h01;
  localparam period_t PERIOD_MAX_S = 7'h63;

  // Manipulated variable in percent.
  localparam int MV_W = 7;
  typedef logic [MV_W-1:0] mv_t;
  localparam mv_t MV_FULL_PCT = 7'h64;

  // Period slot timing: one slot is one hundredth of a second.
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  localparam int unsigned SLOT_TIME_MS = 10;
  localparam int unsigned SLOTS_PER_SECOND = 1000 / SLOT_TIME_MS;
  localparam int unsigned SLOT_CYCLES_DEFAULT = SLOT_TIME_MS * CLK_FREQ_KHZ;

  localparam int DEV_W = 16;

  typedef enum logic [2:0] {
    CFG_CTL1 = 3'h0,
    CFG_CTL2 = 3'h1,
    CFG_AUX1 = 3'h2,
    CFG_AUX2 = 3'h3,
    CFG_DIRECTION = 3'h4,
    CFG_PERIOD_HEAT = 3'h5,
    CFG_PERIOD_COOL = 3'h6,
    CFG_NONE = 3'h7
  } cfg_target_t;

  typedef struct packed {
    logic valid;
    cfg_target_t target;
    logic [7:0] value;
  } cfg_write_t;

  typedef struct packed {
    logic adcError;
    logic inputError;
    logic stageOut;
    logic programEnd;
    logic timeSignal2;
    logic timeSignal1;
    logic loopBreakAlarm;
    logic heaterBurnoutAlarm;
    logic alarm3;
    logic alarm2;
    logic alarm1;
  } func_inputs_t;

  typedef struct packed {
    logic aux2;
    logic aux1;
    logic ctl2;
    logic ctl1;
  } dest_outputs_t;

endpackage

// file: verilog/time_proportional_pulse.sv
`timescale 1ns/10ps
module time_proportional_pulse
  import output_router_pkg::*;
#(
  parameter int CNT_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slotTick,
  input wire logic enable,
  input wire period_t periodSec,
  input wire mv_t mvPct,
  output logic pulseOut
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic pulse;
  } pulse_state_t;

  pulse_state_t s_q;
  pulse_state_t s_d;

  if (CNT_W < $clog2(int'(PERIOD_MAX_S) * SLOTS_PER_SECOND + 1)) begin : g_bad_width
    $error("time_proportional_pulse: CNT_W too small for the longest period");
  end

  logic [CNT_W-1:0] periodSlots;
  logic [CNT_W-1:0] onSlots;
  logic [CNT_W-1:0] nextCnt;
  mv_t mvClip;

  always_comb begin
    mvClip = (mvPct > MV_FULL_PCT) ? MV_FULL_PCT : mvPct;
    periodSlots = CNT_W'(int'(periodSec) * SLOTS_PER_SECOND);
    onSlots = CNT_W'(int'(mvClip) * int'(periodSec));
    nextCnt = (s_q.cnt >= periodSlots - CNT_W'(1)) ? '0 : s_q.cnt + CNT_W'(1);
    s_d = s_q;
    if (!enable) begin
      s_d = '0;
    end else if (slotTick) begin
      s_d.cnt = nextCnt;
      s_d.pulse = (nextCnt < onSlots);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulseOut = s_q.pulse;

endmodule

// file: verilog/output_assignment_router.sv
`timescale 1ns/10ps
module output_assignment_router
  import output_router_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic isPositionType,
  input wire logic factoryInit,
  input wire cfg_write_t cfgWrite,
  input wire func_inputs_t funcIn,
  input wire mv_t heatMv,
  input wire mv_t coolMv,
  input wire logic signed [DEV_W-1:0] processValue,
  input wire logic signed [DEV_W-1:0] setPoint,
  output dest_outputs_t routedOut,
  output dest_map_t assignMap,
  output logic directAction,
  output logic heatCoolMode,
  output period_t periodHeatSec,
  output period_t periodCoolSec,
  output logic coolPeriodLocked,
  output logic cfgRejected,
  output logic signed [DEV_W:0] controlDeviation
);

  localparam int DIV_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;

  if (SLOT_CYCLES < 1) begin : g_bad_slot
    $error("output_assignment_router: SLOT_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic slotTick;
    dest_map_t map;
    logic direction;
    period_t periodHeat;
    period_t periodCool;
    dest_outputs_t outs;
    logic rejected;
    logic signed [DEV_W:0] deviation;
  } router_state_t;

  router_state_t s_q;
  router_state_t s_d;

  logic heatPulse;
  logic coolPulse;

  function automatic logic routeLegal(input func_code_t f, input dest_idx_t d,
                                      input logic pos);
    logic toCtl;
    logic ok;
    toCtl = (d == DEST_CTL1) || (d == DEST_CTL2);
    ok = 1'b0;
    if (f >= FN_ADC_ERROR) begin
      ok = 1'b0;
    end else if (pos) begin
      ok = !toCtl && (f != FN_HEAT) && (f != FN_COOL) &&
           (f != FN_HEATER_BURNOUT) && (f != FN_LOOP_BREAK);
    end else if ((f == FN_HEAT) || (f == FN_COOL)) begin
      ok = toCtl;
    end else if (f == FN_INPUT_ERROR) begin
      ok = !toCtl;
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic funcAssigned(input dest_map_t m, input func_code_t f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DEST; i++) begin
      hit = hit | (m[i] == f);
    end
    return hit;
  endfunction

  logic coolAssigned;
  logic heatAssigned;
  logic [NUM_FUNC_CODES-1:0] srcVec;
  logic validPeriod;
  func_code_t wrCode;
  dest_idx_t wrDest;

  always_comb begin
    coolAssigned = !isPositionType && funcAssigned(s_q.map, FN_COOL);
    heatAssigned = !isPositionType && funcAssigned(s_q.map, FN_HEAT);
    srcVec = '0;
    srcVec[FN_HEAT] = heatPulse;
    srcVec[FN_COOL] = coolPulse;
    srcVec[FN_ALARM1] = funcIn.alarm1;
    srcVec[FN_ALARM2] = funcIn.alarm2;
    srcVec[FN_ALARM3] = funcIn.alarm3;
    srcVec[FN_HEATER_BURNOUT] = funcIn.heaterBurnoutAlarm;
    srcVec[FN_LOOP_BREAK] = funcIn.loopBreakAlarm;
    srcVec[FN_TIME_SIGNAL1] = funcIn.timeSignal1;
    srcVec[FN_TIME_SIGNAL2] = funcIn.timeSignal2;
    srcVec[FN_PROGRAM_END] = funcIn.programEnd;
    srcVec[FN_STAGE] = funcIn.stageOut;
    srcVec[FN_INPUT_ERROR] = funcIn.inputError;
    srcVec[FN_ADC_ERROR] = funcIn.adcError;
    wrCode = cfgWrite.value[FUNC_W-1:0];
    wrDest = cfgWrite.target[1:0];
    validPeriod = (cfgWrite.value[7] == 1'b0) &&
                  (cfgWrite.value[PERIOD_W-1:0] >= PERIOD_MIN_S) &&
                  (cfgWrite.value[PERIOD_W-1:0] <= PERIOD_MAX_S);

    s_d = s_q;
    s_d.rejected = 1'b0;

    if (s_q.div >= DIV_W'(SLOT_CYCLES - 1)) begin
      s_d.div = '0;
      s_d.slotTick = 1'b1;
    end else begin
      s_d.div = s_q.div + DIV_W'(1);
      s_d.slotTick = 1'b0;
    end

    if (factoryInit) begin
      s_d.map[DEST_CTL1] = DEFAULT_CTL1;
      s_d.map[DEST_CTL2] = DEFAULT_CTL2;
      s_d.map[DEST_AUX1] = DEFAULT_AUX1;
      s_d.map[DEST_AUX2] = DEFAULT_AUX2;
      s_d.direction = DEFAULT_DIRECTION;
      s_d.periodHeat = PERIOD_HEAT_DEFAULT_S;
      s_d.periodCool = PERIOD_COOL_DEFAULT_S;
    end else if (cfgWrite.valid) begin
      case (cfgWrite.target)
        CFG_CTL1, CFG_CTL2, CFG_AUX1, CFG_AUX2: begin
          if ((cfgWrite.value[7:FUNC_W] == '0) &&
              routeLegal(wrCode, wrDest, isPositionType)) begin
            s_d.map[wrDest] = wrCode;
          end else begin
            s_d.rejected = 1'b1;
          end
        end
        CFG_DIRECTION: begin
          if (isPositionType || (cfgWrite.value[7:1] != '0)) begin
            s_d.rejected = 1'b1;
          end else begin
            s_d.direction = cfgWrite.value[0];
          end
        end
        CFG_PERIOD_HEAT: begin
          if (isPositionType || !validPeriod) begin
            s_d.rejected = 1'b1;
          end else begin
            s_d.periodHeat = cfgWrite.value[PERIOD_W-1:0];
          end
        end
        CFG_PERIOD_COOL: begin
          if (!coolAssigned || !validPeriod) begin
            s_d.rejected = 1'b1;
          end else begin
            s_d.periodCool = cfgWrite.value[PERIOD_W-1:0];
          end
        end
        default: begin
          s_d.rejected = 1'b1;
        end
      endcase
    end

    s_d.outs.ctl1 = !isPositionType && srcVec[s_q.map[DEST_CTL1]];
    s_d.outs.ctl2 = !isPositionType && srcVec[s_q.map[DEST_CTL2]];
    s_d.outs.aux1 = srcVec[s_q.map[DEST_AUX1]];
    s_d.outs.aux2 = srcVec[s_q.map[DEST_AUX2]];

    if (s_q.direction == DIR_DIRECT) begin
      s_d.deviation = (DEV_W+1)'(processValue) - (DEV_W+1)'(setPoint);
    end else begin
      s_d.deviation = (DEV_W+1)'(setPoint) - (DEV_W+1)'(processValue);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.div <= '0;
      s_q.slotTick <= 1'b0;
      s_q.map[DEST_CTL1] <= DEFAULT_CTL1;
      s_q.map[DEST_CTL2] <= DEFAULT_CTL2;
      s_q.map[DEST_AUX1] <= DEFAULT_AUX1;
      s_q.map[DEST_AUX2] <= DEFAULT_AUX2;
      s_q.direction <= DEFAULT_DIRECTION;
      s_q.periodHeat <= PERIOD_HEAT_DEFAULT_S;
      s_q.periodCool <= PERIOD_COOL_DEFAULT_S;
      s_q.outs <= '0;
      s_q.rejected <= 1'b0;
      s_q.deviation <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  time_proportional_pulse u_heat_pulse (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .slotTick(s_q.slotTick),
    .enable(heatAssigned),
    .periodSec(s_q.periodHeat),
    .mvPct(heatMv),
    .pulseOut(heatPulse)
  );

  time_proportional_pulse u_cool_pulse (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .slotTick(s_q.slotTick),
    .enable(coolAssigned),
    .periodSec(s_q.periodCool),
    .mvPct(coolMv),
    .pulseOut(coolPulse)
  );

  assign routedOut = s_q.outs;
  assign assignMap = s_q.map;
  assign directAction = s_q.direction;
  assign heatCoolMode = coolAssigned;
  assign periodHeatSec = s_q.periodHeat;
  assign periodCoolSec = s_q.periodCool;
  assign coolPeriodLocked = !coolAssigned;
  assign cfgRejected = s_q.rejected;
  assign controlDeviation = s_q.deviation;

endmodule

// file: verif/output_router_assertions.sv
`timescale 1ns/10ps
module output_router_assertions
  import output_router_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic isPositionType,
  input wire logic factoryInit,
  input wire cfg_write_t cfgWrite,
  input wire func_inputs_t funcIn,
  input wire logic signed [DEV_W-1:0] processValue,
  input wire logic signed [DEV_W-1:0] setPoint,
  input wire dest_outputs_t routedOut,
  input wire dest_map_t assignMap,
  input wire logic directAction,
  input wire logic heatCoolMode,
  input wire period_t periodCoolSec,
  input wire logic coolPeriodLocked,
  input wire logic cfgRejected,
  input wire logic signed [DEV_W:0] controlDeviation
);
  logic coolSeen;
  assign coolSeen = (assignMap[0] == FN_COOL) || (assignMap[1] == FN_COOL) ||
    (assignMap[2] == FN_COOL) || (assignMap[3] == FN_COOL);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  cool_lock_mode_a:
    assert property (cfgWrite.valid && !factoryInit && cfgWrite.target == CFG_PERIOD_COOL &&
      coolPeriodLocked |=> cfgRejected) else $error("cool period write not refused");
  heat_cool_mode_a:
    assert property (heatCoolMode == (!isPositionType && coolSeen)) else $error("mode wrong");
  aux_routing_a:
    assert property ($past(rst_b) && $past(assignMap[2]) == FN_ALARM2
      |-> routedOut.aux1 == $past(funcIn.alarm2)) else $error("aux1 route wrong");
  deviation_sign_a:
    assert property ($past(rst_b) && $stable(directAction) |-> controlDeviation == (directAction
      ? $past(processValue) - $past(setPoint) : $past(setPoint) - $past(processValue)))
    else $error("deviation wrong");
  refused_keeps_a:
    assert property (cfgRejected |-> $stable(assignMap) && $stable(directAction))
    else $error("refused write changed state");
  factory_load_a:
    assert property (factoryInit |=> assignMap == {FN_ALARM3, FN_ALARM2, FN_ALARM1, FN_HEAT}
      && !directAction) else $error("factory load wrong");
  position_ctl_off_a:
    assert property (isPositionType && $past(isPositionType) |-> !routedOut.ctl1 && !routedOut.ctl2)
    else $error("control output driven");
  cool_period_held_a:
    assert property ($past(rst_b) && $past(coolPeriodLocked) && !$past(factoryInit)
      |-> $stable(periodCoolSec)) else $error("locked cool period changed");
  legal_map_a:
    assert property (assignMap[0] != FN_INPUT_ERROR && assignMap[1] != FN_INPUT_ERROR &&
      assignMap[2] > FN_COOL && assignMap[3] > FN_COOL && assignMap[2] < FN_ADC_ERROR &&
      assignMap[3] < FN_ADC_ERROR) else $error("illegal assignment held");
endmodule

bind output_assignment_router output_router_assertions u_output_router_assertions (
  .core_clk, .rst_b, .isPositionType, .factoryInit, .cfgWrite, .funcIn, .processValue, .setPoint,
  .routedOut, .assignMap, .directAction, .heatCoolMode, .periodCoolSec, .coolPeriodLocked,
  .cfgRejected, .controlDeviation);

// file: verif/relay_bank.sv
`timescale 1ns/10ps
module relay_bank
  import output_router_pkg::*;
(
  input wire logic core_clk,
  input wire logic clear,
  input wire dest_outputs_t routedOut,
  output logic [15:0] heatOnCycles
);
  // Counts the cycles the control output 1 (ctl1) relay contact is closed since the last clear, whatever function is routed to it.
  always_ff @(posedge core_clk) begin
    if (clear) begin
      heatOnCycles <= 16'h0;
    end else if (routedOut.ctl1) begin
      heatOnCycles <= heatOnCycles + 16'h1;
    end
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb
  import output_router_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic isPositionType = 1'b0;
  logic factoryInit = 1'b0;
  logic clear = 1'b0;
  cfg_write_t cfgWrite = '0;
  func_inputs_t funcIn = '0;
  mv_t heatMv = 7'h00;
  mv_t coolMv = 7'h00;
  logic signed [DEV_W-1:0] processValue = 16'sh0;
  logic signed [DEV_W-1:0] setPoint = 16'sh0;
  dest_outputs_t routedOut;
  dest_map_t assignMap;
  logic directAction, heatCoolMode, coolPeriodLocked, cfgRejected;
  period_t periodHeatSec, periodCoolSec;
  logic signed [DEV_W:0] controlDeviation;
  logic [15:0] heatOnCycles;
  mv_t mvTab[3] = '{7'h1E, 7'h7F, 7'h00};
  logic [15:0] onTab[3] = '{16'h258, 16'h7D0, 16'h0};
  int nMismatch = 0;
  int samplesChecked = 0;

  always #2 core_clk = ~core_clk;

  output_assignment_router #(.SLOT_CYCLES(1)) u_output_assignment_router (
    .core_clk(core_clk), .rst_b(rst_b), .isPositionType(isPositionType),
    .factoryInit(factoryInit), .cfgWrite(cfgWrite), .funcIn(funcIn), .heatMv(heatMv),
    .coolMv(coolMv), .processValue(processValue), .setPoint(setPoint), .routedOut(routedOut),
    .assignMap(assignMap), .directAction(directAction), .heatCoolMode(heatCoolMode),
    .periodHeatSec(periodHeatSec), .periodCoolSec(periodCoolSec),
    .coolPeriodLocked(coolPeriodLocked), .cfgRejected(cfgRejected),
    .controlDeviation(controlDeviation));

  relay_bank u_relay_bank (.core_clk(core_clk), .clear(clear), .routedOut(routedOut),
    .heatOnCycles(heatOnCycles));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cfg(input cfg_target_t t, input logic [7:0] v, input logic rej);
    @(posedge core_clk) #1;
    cfgWrite = '{1'b1, t, v};
    tick(1);
    cfgWrite.valid = 1'b0;
    check(cfgRejected, rej);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    tick(16);
    rst_b = 1'h1;
    check(assignMap, 16'h4320);
    check(directAction, 1'h0);
    check(periodHeatSec, 7'h14);
    check({heatCoolMode, coolPeriodLocked}, 2'h1);
    $display("Test reset done");
    cfg(CFG_AUX1, 8'h00, 1'h1);
    cfg(CFG_AUX2, 8'h01, 1'h1);
    cfg(CFG_CTL1, 8'h0B, 1'h1);
    cfg(CFG_CTL2, 8'h0C, 1'h1);
    cfg(CFG_CTL2, 8'h12, 1'h1);
    cfg(CFG_PERIOD_COOL, 8'h1E, 1'h1);
    cfg(CFG_NONE, 8'h00, 1'h1);
    check(assignMap, 16'h4320);
    $display("Test refusals done");
    for (int c = 2; c < 12; c++) begin
      cfg(CFG_AUX1, 8'(c), 1'h0);
      funcIn = 11'h1 << (c - 2);
      tick(2);
      check(routedOut.aux1, 1'h1);
      funcIn = '0;
      tick(2);
      check(routedOut.aux1, 1'h0);
    end
    cfg(CFG_PERIOD_HEAT, 8'h85, 1'h1);
    cfg(CFG_PERIOD_HEAT, 8'h01, 1'h0);
    check(periodHeatSec, 7'h01);
    cfg(CFG_PERIOD_HEAT, 8'h14, 1'h0);
    $display("Test routing done");
    cfg(CFG_CTL2, 8'h01, 1'h0);
    check({heatCoolMode, coolPeriodLocked}, 2'h2);
    cfg(CFG_PERIOD_COOL, 8'h00, 1'h1);
    cfg(CFG_PERIOD_COOL, 8'h64, 1'h1);
    cfg(CFG_PERIOD_COOL, 8'h63, 1'h0);
    check(periodCoolSec, 7'h63);
    cfg(CFG_CTL1, 8'h01, 1'h0);
    coolMv = 7'h32;
    cfg(CFG_PERIOD_COOL, 8'h01, 1'h0);
    tick(300);
    clear = 1'h1;
    tick(1);
    clear = 1'h0;
    tick(100);
    check(heatOnCycles, 16'h32);
    cfg(CFG_CTL1, 8'h00, 1'h0);
    cfg(CFG_CTL2, 8'h02, 1'h0);
    check({heatCoolMode, coolPeriodLocked}, 2'h1);
    $display("Test cooling done");
    processValue = 16'sh0005;
    setPoint = 16'sh0008;
    tick(2);
    check({15'h0, controlDeviation}, 32'h3);
    cfg(CFG_DIRECTION, 8'h01, 1'h0);
    tick(2);
    check({15'h0, controlDeviation}, 32'h1FFFD);
    cfg(CFG_DIRECTION, 8'h02, 1'h1);
    $display("Test direction done");
    check(periodHeatSec, 7'h14);
    foreach (mvTab[i]) begin
      heatMv = mvTab[i];
      tick(2100);
      clear = 1'h1;
      tick(1);
      clear = 1'h0;
      tick(2000);
      check(heatOnCycles, onTab[i]);
    end
    $display("Test pulse done");
    cfgWrite = '{1'h1, CFG_AUX2, 8'h05};
    factoryInit = 1'h1;
    tick(1);
    factoryInit = 1'h0;
    cfgWrite.valid = 1'h0;
    check(assignMap, 16'h4320);
    check(cfgRejected, 1'h0);
    check(directAction, 1'h0);
    check(periodCoolSec, 7'h14);
    $display("Test factory done");
    rst_b = 1'h0;
    isPositionType = 1'h1;
    tick(16);
    rst_b = 1'h1;
    funcIn = '1;
    cfg(CFG_CTL2, 8'h02, 1'h1);
    cfg(CFG_AUX1, 8'h05, 1'h1);
    cfg(CFG_DIRECTION, 8'h01, 1'h1);
    cfg(CFG_PERIOD_HEAT, 8'h1E, 1'h1);
    cfg(CFG_AUX1, 8'h0A, 1'h0);
    tick(2);
    check(routedOut, 4'hC);
    check({heatCoolMode, directAction}, 2'h0);
    $display("Test position done");
    summarize();
  end
endmodule
